// ===== mic_defines.svh
// Offsets, field positions, reset values and codes of the controller
`ifndef MIC_DEFINES_SVH
`define MIC_DEFINES_SVH
// -----------------------------------------------------------------
// Register indices; byte address is four times the index
// -----------------------------------------------------------------
`define MIC_IDX_EOI    8'h22
`define MIC_IDX_POLLST 8'h26
`define MIC_IDX_PRIMSK 8'h2A
`define MIC_IDX_INSERV 8'h2C
`define MIC_IDX_REQST  8'h2E
`define MIC_IDX_CTL5   8'h34
`define MIC_IDX_CTL6   8'h36
`define MIC_IDX_CTL0   8'h38
`define MIC_IDX_CTL1   8'h3A
`define MIC_IDX_CTL2   8'h3C
`define MIC_IDX_CTL3   8'h3E
`define MIC_IDX_CTL4   8'h40
// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define MIC_BIT_NONSPEC 15
`define MIC_BIT_POLLREQ 15
`define MIC_CTL_WIDE    7
`define MIC_CTL_NARROW  5
// -----------------------------------------------------------------
// Reset values and codes
// -----------------------------------------------------------------
`define MIC_CTL_RST   7'h0F
`define MIC_PMASK_RST 3'h7
`define MIC_BASE_TYPE 8'h0C
`define MIC_ESC_TYPE  8'h07
`define MIC_ESC_OP    5'h1B
`endif

// ===== mic_pkg.sv
// Types shared by the master-mode interrupt controller
package mic_pkg;

  typedef struct packed {
    logic       special_nesting_bit;
    logic       cascade;
    logic       level_trigger_bit;
    logic       source_block_bit;
    logic [2:0] priority_level_field;
  } mic_ctl_t;

  // Gray order along the acknowledge path
  typedef enum logic [2:0] {
    MIC_IDLE = 3'h0,
    MIC_A1A  = 3'h1,
    MIC_A1S  = 3'h3,
    MIC_GAP1 = 3'h2,
    MIC_GAP2 = 3'h6,
    MIC_A2A  = 3'h7,
    MIC_A2S  = 3'h5,
    MIC_DONE = 3'h4
  } mic_ack_t;

  typedef struct packed {
    logic [6:0]     s1;
    logic [6:0]     s2;
    logic [6:0]     s3;
    logic [6:0]     pin;
    logic [1:0]     c1;
    logic [1:0]     c2;
    logic [1:0]     c3;
    logic [1:0]     nr;
    logic [7:0]     b1;
    logic [7:0]     b2;
    logic [7:0]     b3;
    logic [7:0]     bus;
    mic_ctl_t [6:0] ctl;
    logic [6:0]     pend;
    logic [6:0]     insv;
    logic [2:0]     pmask;
    mic_ack_t       ast;
    logic           asrc;
    logic           irq;
    logic [2:0]     isrc;
    logic           vvalid;
    logic [7:0]     vtype;
    logic           nmi_req;
    logic           ale;
    logic           rd_n;
    logic           lock_n;
    logic           ack0_n;
    logic           ack1_n;
    logic           oe0_n;
    logic           oe1_n;
    logic           esc_trap;
    logic [7:0]     esc_type;
    logic [19:0]    esc_ret;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
  } mic_st_t;

endpackage

// ===== mic_ctrl.sv
// Master-mode interrupt controller with cascade acknowledge sequencer
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "mic_defines.svh"
module mic_ctrl #(
  parameter int AW = 10
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Request pins, bit n is ext_request_n
  input  wire logic [6:0]  ext_request_in,
  input  wire logic        nmi_in,
  // Acknowledge bus
  input  wire logic        ready_in,
  input  wire logic [7:0]  muxed_bus_low_byte,
  output logic             ale_out,
  output logic             rd_n_out,
  output logic             lock_n_out,
  output logic             ack_strobe_zero_n,
  output logic             ack_strobe_zero_oe_n,
  output logic             ack_strobe_one_n,
  output logic             ack_strobe_one_oe_n,
  // Processor core
  input  wire logic        core_take,
  output logic             core_irq,
  output logic             vec_valid,
  output logic       [7:0] vec_type,
  output logic             nmi_req,
  // Instruction decode
  input  wire logic        op_valid,
  input  wire logic  [7:0] op_byte,
  input  wire logic [19:0] op_addr,
  input  wire logic        op_prefixed,
  input  wire logic [19:0] prefix_addr,
  output logic             esc_trap,
  output logic       [7:0] esc_type,
  output logic      [19:0] esc_ret
);

  if (AW < 10)
  begin : g_chk
    $error("AW too narrow for the register map");
  end

  // Secondary order among equal levels, best first
  localparam logic [2:0] ORD [7] = '{3'h5, 3'h6, 3'h0, 3'h1,
                                     3'h2, 3'h3, 3'h4};

  mic_pkg::mic_st_t st;
  mic_pkg::mic_st_t n;

  // -----------------------------------------------------------------
  // Priority resolution
  // -----------------------------------------------------------------
  logic [6:0] elig;
  logic       found;
  logic [2:0] win;
  logic       ifound;
  logic [2:0] iwin;
  logic [2:0] best;
  logic [2:0] ibest;

  always_comb
  begin
    logic [2:0] k;
    logic       blk;
    k      = 3'h0;
    blk    = 1'b0;
    elig   = '0;
    found  = 1'b0;
    win    = 3'h0;
    best   = 3'h7;
    ifound = 1'b0;
    iwin   = 3'h0;
    ibest  = 3'h7;
    for (int i = 0; i < 7; i++)
    begin
      blk = st.insv[i];
      if (i < 2 && st.ctl[i].special_nesting_bit)
        blk = 1'b0;
      for (int j = 0; j < 7; j++)
        if (st.insv[j] && st.ctl[j].priority_level_field
            < st.ctl[i].priority_level_field)
          blk = 1'b1;
      elig[i] = st.pend[i] && !st.ctl[i].source_block_bit && !blk
                && st.ctl[i].priority_level_field <= st.pmask;
    end
    // Pins turned into acknowledge outputs never request
    if (st.ctl[0].cascade)
      elig[2] = 1'b0;
    if (st.ctl[1].cascade)
      elig[3] = 1'b0;
    for (int m = 0; m < 7; m++)
    begin
      k = ORD[m];
      if (elig[k] && (!found
          || st.ctl[k].priority_level_field < best))
      begin
        found = 1'b1;
        win   = k;
        best  = st.ctl[k].priority_level_field;
      end
      if (st.insv[k] && (!ifound
          || st.ctl[k].priority_level_field < ibest))
      begin
        ifound = 1'b1;
        iwin   = k;
        ibest  = st.ctl[k].priority_level_field;
      end
    end
  end

  // -----------------------------------------------------------------
  // Register decode
  // -----------------------------------------------------------------
  logic [7:0]  idx;
  logic        hit;
  logic        is_ctl;
  logic [2:0]  csel;
  logic [31:0] rd;

  always_comb
  begin
    idx    = paddr[9:2];
    hit    = 1'b1;
    is_ctl = 1'b0;
    csel   = 3'h0;
    rd     = '0;
    unique case (idx)
      `MIC_IDX_CTL0: begin is_ctl = 1'b1; csel = 3'h0; end
      `MIC_IDX_CTL1: begin is_ctl = 1'b1; csel = 3'h1; end
      `MIC_IDX_CTL2: begin is_ctl = 1'b1; csel = 3'h2; end
      `MIC_IDX_CTL3: begin is_ctl = 1'b1; csel = 3'h3; end
      `MIC_IDX_CTL4: begin is_ctl = 1'b1; csel = 3'h4; end
      `MIC_IDX_CTL5: begin is_ctl = 1'b1; csel = 3'h5; end
      `MIC_IDX_CTL6: begin is_ctl = 1'b1; csel = 3'h6; end
      `MIC_IDX_INSERV: rd[6:0] = st.insv;
      `MIC_IDX_REQST:  rd[6:0] = st.pend;
      `MIC_IDX_PRIMSK: rd[2:0] = st.pmask;
      `MIC_IDX_POLLST:
      begin
        rd[`MIC_BIT_POLLREQ] = found;
        rd[4:0] = 5'(`MIC_BASE_TYPE + {5'h00, win});
      end
      `MIC_IDX_EOI: rd = '0;
      default: hit = 1'b0;
    endcase
    if (paddr[1:0] != 2'h0 || paddr[AW-1:AW-1] != 1'b0 && AW > 10)
      hit = 1'b0;
    if (is_ctl)
      rd[6:0] = (csel < 3'h2) ? st.ctl[csel]
                : st.ctl[csel] & 7'h1F;
  end

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb
  begin
    logic [6:0] rise;
    logic [6:0] clr;
    logic       take;
    logic       wr;
    logic       stb;
    logic [7:0] t;
    rise = '0;
    clr  = '0;
    take = 1'b0;
    wr   = 1'b0;
    stb  = 1'b0;
    t    = 8'h00;
    n    = st;
    // Three-stage synchronisers; a change needs stages two and three
    n.s1  = ext_request_in;
    n.s2  = st.s1;
    n.s3  = st.s2;
    n.pin = (st.s2 & st.s3) | (st.pin & (st.s2 | st.s3));
    n.c1  = {nmi_in, ready_in};
    n.c2  = st.c1;
    n.c3  = st.c2;
    n.nr  = (st.c2 & st.c3) | (st.nr & (st.c2 | st.c3));
    // A ready seen in one acknowledge cycle must never end the next one
    if (!(st.ast inside {mic_pkg::MIC_A1A, mic_pkg::MIC_A1S,
                         mic_pkg::MIC_A2A, mic_pkg::MIC_A2S}))
      {n.c1[0], n.c2[0], n.c3[0], n.nr[0]} = 4'h0;
    n.b1  = muxed_bus_low_byte;
    n.b2  = st.b1;
    n.b3  = st.b2;
    n.bus = (st.b2 & st.b3) | (st.bus & (st.b2 | st.b3));
    rise  = n.pin & ~st.pin;
    n.nmi_req = n.nr[1] & ~st.nr[1];
    // Escape opcodes trap unconditionally
    n.esc_trap = op_valid && op_byte[7:3] == `MIC_ESC_OP;
    if (n.esc_trap)
    begin
      n.esc_type = `MIC_ESC_TYPE;
      n.esc_ret  = op_prefixed ? prefix_addr : op_addr;
    end
    // APB: answer one cycle after setup
    n.pready = psel && !penable;
    wr = psel && penable && st.pready && pwrite && hit;
    if (n.pready)
    begin
      n.pslverr = !hit;
      n.prdata  = (pwrite || !hit) ? 32'h0000_0000 : rd;
    end
    if (wr && is_ctl)
      n.ctl[csel] = (csel < 3'h2) ? pwdata[6:0]
                    : {2'b00, pwdata[4:0]};
    if (wr && idx == `MIC_IDX_PRIMSK)
      n.pmask = pwdata[2:0];
    if (wr && idx == `MIC_IDX_EOI)
    begin
      t = pwdata[7:0];
      if (pwdata[`MIC_BIT_NONSPEC])
        clr[iwin] = ifound;
      else if (t >= `MIC_BASE_TYPE && t < 8'(`MIC_BASE_TYPE + 8'h07))
        clr[3'(t - `MIC_BASE_TYPE)] = 1'b1;
    end
    n.insv = st.insv & ~clr;
    // Pending: level follows the pin, edge is sticky
    take = core_take && st.irq;
    for (int i = 0; i < 7; i++)
      if (st.ctl[i].level_trigger_bit)
        n.pend[i] = n.pin[i];
      else if (rise[i])
        n.pend[i] = 1'b1;
      else if (take && st.isrc == 3'(i))
        n.pend[i] = 1'b0;
    n.vvalid = 1'b0;
    if (take)
    begin
      n.irq = 1'b0;
      // Set wins over a done write in the same cycle
      n.insv[st.isrc] = 1'b1;
      if (st.isrc < 3'h2 && st.ctl[st.isrc].cascade)
      begin
        n.ast  = mic_pkg::MIC_A1A;
        n.asrc = st.isrc[0];
      end
      else
      begin
        n.vvalid = 1'b1;
        n.vtype  = 8'(`MIC_BASE_TYPE + {5'h00, st.isrc});
      end
    end
    else if (st.ast == mic_pkg::MIC_IDLE)
    begin
      n.irq  = found;
      n.isrc = win;
    end
    // Locked acknowledge pair
    unique case (st.ast)
      mic_pkg::MIC_IDLE: ;
      mic_pkg::MIC_A1A:  n.ast = mic_pkg::MIC_A1S;
      mic_pkg::MIC_A1S:
        if (st.nr[0])
          n.ast = mic_pkg::MIC_GAP1;
      mic_pkg::MIC_GAP1: n.ast = mic_pkg::MIC_GAP2;
      mic_pkg::MIC_GAP2: n.ast = mic_pkg::MIC_A2A;
      mic_pkg::MIC_A2A:  n.ast = mic_pkg::MIC_A2S;
      mic_pkg::MIC_A2S:
        if (st.nr[0])
        begin
          n.ast    = mic_pkg::MIC_DONE;
          n.vvalid = 1'b1;
          n.vtype  = st.bus;
        end
      mic_pkg::MIC_DONE: n.ast = mic_pkg::MIC_IDLE;
    endcase
    // Pin outputs registered from the next state
    n.ale = n.ast == mic_pkg::MIC_A1A
            || n.ast == mic_pkg::MIC_A2A;
    n.rd_n = 1'b1;
    stb = n.ast == mic_pkg::MIC_A1S || n.ast == mic_pkg::MIC_A2S;
    n.lock_n = n.ast == mic_pkg::MIC_IDLE
               || n.ast == mic_pkg::MIC_DONE;
    n.ack0_n = !(stb && !n.asrc);
    n.ack1_n = !(stb && n.asrc);
    n.oe0_n  = !n.ctl[0].cascade;
    n.oe1_n  = !n.ctl[1].cascade;
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st          <= '0;
      st.ctl      <= {7{`MIC_CTL_RST}};
      st.rd_n     <= 1'b1;
      st.pmask    <= `MIC_PMASK_RST;
      st.ast      <= mic_pkg::MIC_IDLE;
      st.lock_n   <= 1'b1;
      st.ack0_n   <= 1'b1;
      st.ack1_n   <= 1'b1;
      st.oe0_n    <= 1'b1;
      st.oe1_n    <= 1'b1;
      st.esc_type <= `MIC_ESC_TYPE;
    end
    else
      st <= n;
  end

  assign prdata               = st.prdata;
  assign pready               = st.pready;
  assign pslverr              = st.pslverr;
  assign ale_out              = st.ale;
  assign rd_n_out             = st.rd_n;
  assign lock_n_out           = st.lock_n;
  assign ack_strobe_zero_n    = st.ack0_n;
  assign ack_strobe_zero_oe_n = st.oe0_n;
  assign ack_strobe_one_n     = st.ack1_n;
  assign ack_strobe_one_oe_n  = st.oe1_n;
  assign core_irq             = st.irq;
  assign vec_valid            = st.vvalid;
  assign vec_type             = st.vtype;
  assign nmi_req              = st.nmi_req;
  assign esc_trap             = st.esc_trap;
  assign esc_type             = st.esc_type;
  assign esc_ret              = st.esc_ret;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_esc_trap_type: assert property (
    op_valid && op_byte[7:3] == 5'h1B |=> esc_trap && esc_type == 8'h07)
    else $error("escape opcode did not trap");

  a_esc_ret_addr: assert property (
    op_valid && op_byte[7:3] == 5'h1B
    |=> esc_ret == ($past(op_prefixed) ? $past(prefix_addr)
                                       : $past(op_addr)))
    else $error("escape return address wrong");

  a_internal_no_ack: assert property (
    core_take && core_irq
    && !(st.isrc < 3'h2 && st.ctl[st.isrc].cascade)
    |=> vec_valid && lock_n_out && !ale_out
        && ack_strobe_zero_n && ack_strobe_one_n)
    else $error("internal type with acknowledge cycles");

  a_ack_gap_two: assert property (
    st.ast == mic_pkg::MIC_A1S && st.nr[0]
    |=> !ale_out && !lock_n_out ##1 !ale_out && !lock_n_out
        ##1 ale_out)
    else $error("idle gap between acknowledges not two");

  a_ack_wait_ready: assert property (
    !(ack_strobe_zero_n && ack_strobe_one_n) && !st.nr[0]
    |=> !(ack_strobe_zero_n && ack_strobe_one_n))
    else $error("acknowledge ended without ready");

  a_ale_rd_pulse: assert property (
    $fell(lock_n_out) |-> ale_out && rd_n_out ##1 !ale_out && rd_n_out)
    else $error("latch strobe or read strobe wrong");

  a_same_src_block: assert property (
    core_irq && !(st.isrc < 3'h2 && st.ctl[st.isrc].special_nesting_bit)
    |-> !st.insv[st.isrc])
    else $error("source in service raised again");

  a_lower_block: assert property (
    core_irq |-> !(|(st.insv & ~elig & ~(7'h01 << st.isrc)))
                 || st.ctl[st.isrc].priority_level_field
                    <= st.ctl[iwin].priority_level_field)
    else $error("lower priority served over higher");

  a_cascade_pins: assert property (
    core_irq |-> !(st.isrc == 3'h2 && st.ctl[0].cascade)
                 && !(st.isrc == 3'h3 && st.ctl[1].cascade))
    else $error("acknowledge pin treated as request");

endmodule

// ===== mic_pic_model.sv
// Far-side model of the cascaded interrupt controllers
`timescale 1ns/100ps
module mic_pic_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Acknowledge bus
  input  wire logic       lock_n,
  input  wire logic       ack0_n,
  input  wire logic       ack1_n,
  output logic            ready,
  output logic [7:0]      bus,
  // Bench settings
  input  wire logic [3:0] slow,
  input  wire logic [7:0] vec0,
  input  wire logic [7:0] vec1
);
  logic       stb;
  logic       was;
  logic       sec;
  logic       src;
  logic [3:0] cnt;
  logic [7:0] nz;

  assign stb = !(ack0_n && ack1_n);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      was <= 1'b0;
      sec <= 1'b0;
      src <= 1'b0;
      cnt <= 4'h0;
      nz  <= 8'hA5;
    end
    else
    begin
      // Released bus changes every cycle so a stale byte never passes
      nz  <= nz + 8'h3B;
      was <= stb;
      cnt <= stb ? cnt + {3'h0, cnt != 4'hF} : 4'h0;
      if (stb)
        src <= !ack1_n;
      sec <= !lock_n && (sec || (was && !stb));
    end
  end

  assign ready = slow == 4'h0 || (stb && cnt >= slow);
  // Byte offered from the second idle state until the pair ends
  assign bus = sec ? (src ? vec1 : vec0) : nz;
endmodule

// ===== master_mode_interrupt_controller_tb_top.sv
// Self-checking bench of the master-mode interrupt controller
`timescale 1ns/100ps
`include "mic_defines.svh"
module master_mode_interrupt_controller_tb_top;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, e, opv, opp, trap;
  logic        nmi_in, ready, ale, rd_n, lock_n, take_s, irq, vv;
  logic        pready, pslverr, nmi_q;
  logic        a0n, a0oe_n, a1n, a1oe_n;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [6:0]  req, pins;
  logic [7:0]  bus, vt, et, opb, t, v0, v1;
  logic [19:0] opa, pa, eret, a;
  logic [3:0]  slow;
  int          miscompares = 0, total_checks = 0;
  int          n_ale = 0, n_gap = 0, n_stb = 0, n_rd = 0, n_nmi = 0;
  int          i, b_ale, b_gap, b_stb;
  localparam logic [7:0] RIX [10] = '{`MIC_IDX_CTL0, `MIC_IDX_CTL1,
    `MIC_IDX_CTL2, `MIC_IDX_CTL3, `MIC_IDX_CTL4, `MIC_IDX_CTL5,
    `MIC_IDX_CTL6, `MIC_IDX_PRIMSK, `MIC_IDX_INSERV, `MIC_IDX_REQST};

  always #2 pclk = ~pclk;
  // Pins two and three carry the acknowledge strobes when cascaded
  assign pins = {req[6:4], a1oe_n ? req[3] : a1n, a0oe_n ? req[2] : a0n,
                 req[1:0]};

  mic_ctrl #(.AW(10)) u_mic_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_request_in(pins),
    .nmi_in(nmi_in), .ready_in(ready), .muxed_bus_low_byte(bus),
    .ale_out(ale), .rd_n_out(rd_n), .lock_n_out(lock_n),
    .ack_strobe_zero_n(a0n), .ack_strobe_zero_oe_n(a0oe_n),
    .ack_strobe_one_n(a1n), .ack_strobe_one_oe_n(a1oe_n),
    .core_take(take_s), .core_irq(irq), .vec_valid(vv), .vec_type(vt),
    .nmi_req(nmi_q), .op_valid(opv), .op_byte(opb), .op_addr(opa),
    .op_prefixed(opp), .prefix_addr(pa), .esc_trap(trap),
    .esc_type(et), .esc_ret(eret));

  mic_pic_model u_mic_pic_model (
    .pclk(pclk), .presetn(presetn), .lock_n(lock_n), .ack0_n(a0n),
    .ack1_n(a1n), .ready(ready), .bus(bus), .slow(slow), .vec0(v0),
    .vec1(v1));

  always @(posedge pclk)
  begin
    n_ale <= n_ale + int'(ale);
    n_gap <= n_gap + int'(!lock_n && a0n && a1n && !ale);
    n_stb <= n_stb + int'(!(a0n && a1n));
    n_rd  <= n_rd + int'(presetn && !rd_n);
    n_nmi <= n_nmi + int'(nmi_q);
  end

  // ------------------------------
  // Bench tasks
  // ------------------------------
  task automatic chk(input string s, input logic [31:0] x, y);
    total_checks++;
    if (y !== x)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", s, x, y);
    end
  endtask

  task automatic test_done;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic hang(input string s);
    miscompares++;
    $display("BAD %s expected answer seen none", s);
    test_done;
  endtask

  // Returns one edge after the access phase has ended
  task automatic apb(input logic w, input logic [7:0] ix,
                     input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {ix, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge pclk);
    if (n == 20)
      hang("pready");
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic do_reset;
    req     <= 7'h00;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic chk_reset;
    for (int k = 0; k < 10; k++)
    begin
      apb(1'b0, RIX[k], 32'h0);
      chk("reset value", k < 7 ? 32'hF : {31'h0, k == 7} * 7, r);
    end
    chk("reset pins", 32'h7, {29'h0, lock_n, a0oe_n, a1oe_n});
  endtask

  task automatic irq_wait(input logic x);
    int n;
    for (n = 0; n < 16 && irq !== 1'b1; n++)
      @(posedge pclk);
    chk("core request", {31'h0, x}, {31'h0, irq});
    if (irq !== x)
      test_done;
  endtask

  task automatic take;
    int n;
    take_s <= 1'b1;
    @(posedge pclk);
    take_s <= 1'b0;
    for (n = 0; n < 99 && vv !== 1'b1; n++)
      @(posedge pclk);
    if (n == 99)
      hang("vector");
    t = vt;
  endtask

  task automatic serve(input logic [6:0] m);
    req <= req | m;
    irq_wait(1'b1);
    take;
  endtask

  initial
  begin
    repeat (50000) @(posedge pclk);
    hang("run time");
  end

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, nmi_in, take_s, opv, opp} = 8'h00;
    {paddr, pwdata, req, opb, opa, pa, slow, v0, v1} = '0;
    void'($urandom(32'hC76D9E5D));
    do_reset;
    chk_reset;
    apb(1'b0, 8'h01, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    for (i = 0; i < 12; i++)
    begin
      a    = 20'($urandom);
      opp <= 1'($urandom);
      opb <= i < 8 ? 8'hD8 + 8'(i) : 8'($urandom_range(215));
      opv <= 1'b1;
      opa <= a;
      pa  <= ~a;
      @(posedge pclk);
      opv <= 1'b0;
      @(posedge pclk);
      chk("trap", {31'h0, i < 8}, {31'h0, trap});
      if (i < 8)
      begin
        chk("trap type", 32'h07, {24'h0, et});
        chk("return", {12'h0, opp ? ~a : a}, {12'h0, eret});
      end
    end
    apb(1'b1, `MIC_IDX_CTL4, 32'h05);
    apb(1'b1, `MIC_IDX_CTL5, 32'h02);
    apb(1'b1, `MIC_IDX_CTL6, 32'h06);
    b_ale = n_ale;
    serve(7'h30);
    chk("winner", 32'h11, {24'h0, t});
    req[5] <= 1'b0;
    irq_wait(1'b0);
    apb(1'b1, `MIC_IDX_EOI, 32'h8000);
    serve(7'h00);
    chk("after eoi", 32'h10, {24'h0, t});
    req[4] <= 1'b0;
    repeat (4) @(posedge pclk);
    req[4] <= 1'b1;
    irq_wait(1'b0);
    apb(1'b0, `MIC_IDX_INSERV, 32'h0);
    chk("in service", 32'h10, r);
    apb(1'b1, `MIC_IDX_EOI, 32'h10);
    serve(7'h00);
    req[4] <= 1'b0;
    chk("internal ale", 32'h0, n_ale - b_ale);
    apb(1'b1, `MIC_IDX_EOI, 32'h8000);
    for (i = 0; i < 4; i++)
    begin
      if (!i[0])
      begin
        apb(1'b1, `MIC_IDX_CTL0, i == 0 ? 32'h21 : 32'h0F);
        apb(1'b1, `MIC_IDX_CTL1, i == 0 ? 32'h0F : 32'h21);
        repeat (2) @(posedge pclk);
        chk("ack enables", i / 2 + 1, {30'h0, a0oe_n, a1oe_n});
      end
      slow <= i[0] ? 4'($urandom_range(6, 1)) : 4'h0;
      v0   <= 8'($urandom);
      v1   <= 8'($urandom);
      b_ale = n_ale;
      b_gap = n_gap;
      b_stb = n_stb;
      serve(i < 2 ? 7'h01 : 7'h02);
      req <= 7'h00;
      chk("type byte", {24'h0, i < 2 ? v0 : v1}, {24'h0, t});
      chk("ale pulses", 32'h2, n_ale - b_ale);
      chk("idle states", 32'h2, n_gap - b_gap);
      b_stb = n_stb - b_stb;
      chk("stretch", 32'h1, {31'h0, b_stb >= 2 * slow + 2});
      apb(1'b1, `MIC_IDX_EOI, 32'h8000);
    end
    apb(1'b1, `MIC_IDX_CTL1, 32'h43);
    serve(7'h02);
    req[1] <= 1'b0;
    repeat (4) @(posedge pclk);
    serve(7'h42);
    chk("nested again", 32'h0D, {24'h0, t});
    req[1] <= 1'b0;
    irq_wait(1'b0);
    apb(1'b0, `MIC_IDX_INSERV, 32'h0);
    chk("nested service", 32'h02, r);
    apb(1'b1, `MIC_IDX_EOI, 32'h8000);
    serve(7'h00);
    chk("released", 32'h12, {24'h0, t});
    apb(1'b1, `MIC_IDX_EOI, 32'h8000);
    apb(1'b1, `MIC_IDX_CTL4, 32'h15);
    serve(7'h10);
    chk("level type", 32'h10, {24'h0, t});
    apb(1'b0, `MIC_IDX_REQST, 32'h0);
    chk("level pending", 32'h10, r & 32'h10);
    b_gap = n_nmi;
    nmi_in <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("nmi pulses", 32'h1, n_nmi - b_gap);
    do_reset;
    chk_reset;
    chk("read strobe", 32'h0, n_rd);
    test_done;
  end
endmodule
